//--- scan_map.svh
`ifndef SCAN_MAP_SVH
`define SCAN_MAP_SVH
// Serial word layout
`define WORD_BITS 16
`define ADDR_MSB 15
`define ADDR_LSB 12
`define DATA_MSB 11
// Register addresses carried in the top four bits
`define ADDR_CTRL 4'h0
`define ADDR_NINC 4'h1
`define ADDR_STEP_LO 4'h2
`define ADDR_STEP_HI 4'h3
`define ADDR_START_LO 4'hC
`define ADDR_START_HI 4'hD
// Interval words use the top two bits 01
`define ADDR_INTV_TOP 2'h1
// Control word field positions
`define CTRL_EXT_BIT 5
`define CTRL_CYC_BIT 4
// Reset values
`define FREQ_RESET 24'h000000
`define NINC_RESET 12'h002
`define INTV_RESET 11'h002
// Host serial clock divider: half period in master clocks, less one
`define HOST_HALF_DIV 4'h4
`endif

//--- scan_pkg.sv
package scan_pkg;
	typedef logic [23:0] freq_t;
	typedef logic [15:0] word_t;
	typedef enum logic [1:0] {
		SCAN_IDLE = 2'b00,
		SCAN_RUN = 2'b01,
		SCAN_HOLD = 2'b11
	} scan_state_t;
	typedef enum logic [1:0] {
		HOST_IDLE = 2'b00,
		HOST_LOW = 2'b01,
		HOST_HIGH = 2'b11,
		HOST_END = 2'b10
	} host_state_t;
endpackage

//--- scan_link_if.sv
`timescale 1ns/1ps
interface scan_link_if;
	logic serial_clk;
	logic serial_data_in;
	logic frame_select_n;
	logic trigger;
	logic abort;
	modport device (
		input serial_clk,
		input serial_data_in,
		input frame_select_n,
		input trigger,
		input abort
	);
	modport host (
		output serial_clk,
		output serial_data_in,
		output frame_select_n,
		output trigger,
		output abort
	);
endinterface

//--- scan_device.sv
`timescale 1ns/1ps
`include "scan_map.svh"
// How it works
// - Scan set by start, step, increment count
// - Auto or external pin paced stepping
// - Auto interval counts master clocks or cycles
// - Auto mode: one trigger runs whole scan
// - External mode: first trigger rise starts scan, each later rise steps once
// - Accumulator runs on, only increment changes
// - Final frequency held after last step
// - Start frequency also held one interval
// - Sixteen bit words on serial clock
// - Frame select low enables data shifting
// - Shift one bit per falling serial edge
// - Host drops frame select before first edge
// - Each sixteen bits forms separate word
// - Host raises select after final word
// - Any serial clock idle level works
// - Phase accumulator clocked by master clock
// - Trigger sampled, rising edge starts scan
// - Abort rise resets scan, output midscale
// - Address first, then data MSB first
module scan_device (
	input wire logic i_clk,
	input wire logic i_reset_n,
	scan_link_if.device link,
	output scan_pkg::freq_t o_freq,
	output logic [11:0] o_dac,
	output logic o_msb,
	output logic o_scanning,
	output logic o_done
);
	import scan_pkg::*;
	// ************************************************
	// Input synchronisers
	// ************************************************
	logic [4:0] meta, synced;
	logic [4:0] next_meta, next_synced;
	always_comb begin
		next_meta = {link.serial_clk, link.serial_data_in, link.frame_select_n,
			link.trigger, link.abort};
		next_synced = meta;
	end
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			// Idle pin levels, so no false edge follows reset
			meta <= 5'h14;
			synced <= 5'h14;
		end else begin
			meta <= next_meta;
			synced <= next_synced;
		end
	end
	wire s_sclk = synced[4];
	wire s_sdi = synced[3];
	wire s_fs_n = synced[2];
	wire s_trig = synced[1];
	wire s_abort = synced[0];
	// ************************************************
	// Serial receiver
	// ************************************************
	// Edges found by the master clock, so any idle level of the serial clock is safe
	logic [2:0] edge_d, next_edge_d;
	word_t shreg, next_shreg;
	logic [3:0] bitcnt, next_bitcnt;
	logic wstrobe, next_wstrobe;
	word_t word, next_word;
	logic fall;
	always_comb begin
		next_edge_d = {s_sclk, s_trig, s_abort};
		fall = edge_d[2] & ~s_sclk;
		next_shreg = shreg;
		next_bitcnt = bitcnt;
		next_wstrobe = 1'b0;
		next_word = word;
		if (s_fs_n) begin
			next_bitcnt = 4'h0;
		end else if (fall) begin
			next_shreg = {shreg[14:0], s_sdi};
			next_bitcnt = bitcnt + 4'h1;
			if (bitcnt == 4'hF) begin
				next_wstrobe = 1'b1;
				next_word = {shreg[14:0], s_sdi};
			end
		end
	end
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			edge_d <= 3'h4;
			shreg <= 16'h0000;
			bitcnt <= 4'h0;
			wstrobe <= 1'b0;
			word <= 16'h0000;
		end else begin
			edge_d <= next_edge_d;
			shreg <= next_shreg;
			bitcnt <= next_bitcnt;
			wstrobe <= next_wstrobe;
			word <= next_word;
		end
	end
	// ************************************************
	// Parameter registers
	// ************************************************
	freq_t start_f, step_f, next_start_f, next_step_f;
	logic [11:0] ninc, next_ninc;
	logic [10:0] intv, next_intv;
	logic ext_mode, cyc_mode, next_ext_mode, next_cyc_mode;
	logic ctrl_wr;
	always_comb begin
		next_start_f = start_f;
		next_step_f = step_f;
		next_ninc = ninc;
		next_intv = intv;
		next_ext_mode = ext_mode;
		next_cyc_mode = cyc_mode;
		ctrl_wr = 1'b0;
		if (wstrobe) begin
			if (word[15:14] == `ADDR_INTV_TOP) begin
				next_intv = word[10:0];
			end else begin
				case (word[`ADDR_MSB:`ADDR_LSB])
					`ADDR_CTRL: begin
						ctrl_wr = 1'b1;
						next_ext_mode = word[`CTRL_EXT_BIT];
						next_cyc_mode = word[`CTRL_CYC_BIT];
					end
					`ADDR_NINC: next_ninc = word[`DATA_MSB:0];
					`ADDR_STEP_LO: next_step_f[11:0] = word[`DATA_MSB:0];
					`ADDR_STEP_HI: next_step_f[23:12] = word[`DATA_MSB:0];
					`ADDR_START_LO: next_start_f[11:0] = word[`DATA_MSB:0];
					`ADDR_START_HI: next_start_f[23:12] = word[`DATA_MSB:0];
					default: next_ninc = ninc;
				endcase
			end
		end
	end
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			start_f <= `FREQ_RESET;
			step_f <= `FREQ_RESET;
			ninc <= `NINC_RESET;
			intv <= `INTV_RESET;
			ext_mode <= 1'b0;
			cyc_mode <= 1'b0;
		end else begin
			start_f <= next_start_f;
			step_f <= next_step_f;
			ninc <= next_ninc;
			intv <= next_intv;
			ext_mode <= next_ext_mode;
			cyc_mode <= next_cyc_mode;
		end
	end
	// ************************************************
	// Scan sequencer and accumulator
	// ************************************************
	scan_state_t state, next_state;
	freq_t freq, next_freq, phase, next_phase;
	logic [11:0] steps, next_steps;
	logic [10:0] tick, next_tick;
	logic trig_rise, abort_rise, wrap, step_now;
	logic next_scanning, next_done;
	logic [11:0] next_dac;
	logic next_msb;
	always_comb begin
		trig_rise = s_trig & ~edge_d[1];
		abort_rise = s_abort & ~edge_d[0];
		next_phase = phase + freq;
		wrap = next_phase[23] & ~phase[23];
		next_state = state;
		next_freq = freq;
		next_steps = steps;
		next_tick = tick;
		step_now = 1'b0;
		case (state)
			SCAN_IDLE: begin
				next_phase = 24'h000000;
				if (trig_rise) begin
					next_state = SCAN_RUN;
					next_freq = start_f;
					next_steps = 12'h000;
					next_tick = 11'h000;
				end
			end
			SCAN_RUN: begin
				if (ext_mode) begin
					step_now = trig_rise;
				end else if (!cyc_mode || wrap) begin
					// Counts master clocks or output cycles
					next_tick = tick + 11'h001;
					step_now = (tick + 11'h001) >= intv;
				end
				if (step_now) begin
					next_tick = 11'h000;
					if (steps == ninc) begin
						next_state = SCAN_HOLD;
					end else begin
						next_freq = freq + step_f;
						next_steps = steps + 12'h001;
					end
				end
			end
			SCAN_HOLD: next_state = SCAN_HOLD;
			default: next_state = SCAN_IDLE;
		endcase
		if (abort_rise || ctrl_wr) begin
			next_state = SCAN_IDLE;
			next_freq = 24'h000000;
			next_phase = 24'h000000;
		end
		next_scanning = (next_state == SCAN_RUN);
		next_done = (next_state == SCAN_HOLD);
		// Midscale while idle: phase zero maps to code 800
		next_dac = next_phase[23:12] ^ 12'h800;
		next_msb = ~next_dac[11];
	end
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= SCAN_IDLE;
			freq <= 24'h000000;
			phase <= 24'h000000;
			steps <= 12'h000;
			tick <= 11'h000;
			o_scanning <= 1'b0;
			o_done <= 1'b0;
			o_dac <= 12'h800;
			o_msb <= 1'b0;
		end else begin
			state <= next_state;
			freq <= next_freq;
			phase <= next_phase;
			steps <= next_steps;
			tick <= next_tick;
			o_scanning <= next_scanning;
			o_done <= next_done;
			o_dac <= next_dac;
			o_msb <= next_msb;
		end
	end
	assign o_freq = freq;
endmodule // scan_device

//--- scan_host.sv
`timescale 1ns/1ps
`include "scan_map.svh"
module scan_host (
	input wire logic i_clk,
	input wire logic i_reset_n,
	scan_link_if.host link,
	input wire logic i_valid,
	input scan_pkg::word_t i_word,
	input wire logic i_more,
	input wire logic i_trigger,
	input wire logic i_abort,
	output logic o_ready,
	output logic o_busy
);
	import scan_pkg::*;
	// ************************************************
	// Serial writer
	// ************************************************
	// Frame select drops a half period before the first fall and rises after the last
	host_state_t state, next_state;
	word_t sh, next_sh;
	logic [3:0] div, next_div, bits, next_bits;
	logic sclk, next_sclk, fs_n, next_fs_n, sdo, next_sdo;
	logic trig, abort, ready, next_ready, more, next_more;
	always_comb begin
		next_state = state;
		next_sh = sh;
		next_div = div;
		next_bits = bits;
		next_sclk = sclk;
		next_fs_n = fs_n;
		next_sdo = sdo;
		next_ready = 1'b0;
		next_more = more;
		if (div != 4'h0) begin
			next_div = div - 4'h1;
		end
		case (state)
			HOST_IDLE: begin
				next_ready = 1'b1;
				if (i_valid && ready) begin
					next_ready = 1'b0;
					next_sh = i_word;
					next_more = i_more;
					next_fs_n = 1'b0;
					next_sdo = i_word[15];
					next_bits = 4'h0;
					next_div = `HOST_HALF_DIV;
					next_state = HOST_HIGH;
				end
			end
			HOST_HIGH: if (div == 4'h0) begin
				next_sclk = 1'b0;
				next_div = `HOST_HALF_DIV;
				next_state = HOST_LOW;
			end
			HOST_LOW: if (div == 4'h0) begin
				next_sclk = 1'b1;
				next_div = `HOST_HALF_DIV;
				next_sh = {sh[14:0], 1'b0};
				next_sdo = sh[14];
				next_bits = bits + 4'h1;
				next_state = (bits == 4'hF) ? HOST_END : HOST_HIGH;
			end
			HOST_END: begin
				if (more) begin
					next_ready = 1'b1;
					if (i_valid && ready) begin
						// Streams the next word in the same frame
						next_ready = 1'b0;
						next_sh = i_word;
						next_more = i_more;
						next_sdo = i_word[15];
						next_bits = 4'h0;
						// Full high phase again, so data settles before the next fall
						next_div = `HOST_HALF_DIV;
						next_state = HOST_HIGH;
					end
				end else if (div == 4'h0) begin
					next_fs_n = 1'b1;
					next_state = HOST_IDLE;
				end
			end
			default: next_state = HOST_IDLE;
		endcase
	end
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= HOST_IDLE;
			sh <= 16'h0000;
			div <= 4'h0;
			bits <= 4'h0;
			sclk <= 1'b1;
			fs_n <= 1'b1;
			sdo <= 1'b0;
			trig <= 1'b0;
			abort <= 1'b0;
			ready <= 1'b0;
			more <= 1'b0;
			o_busy <= 1'b0;
		end else begin
			state <= next_state;
			sh <= next_sh;
			div <= next_div;
			bits <= next_bits;
			sclk <= next_sclk;
			fs_n <= next_fs_n;
			sdo <= next_sdo;
			trig <= i_trigger;
			abort <= i_abort;
			ready <= next_ready;
			more <= next_more;
			o_busy <= (next_state != HOST_IDLE);
		end
	end
	assign o_ready = ready;
	assign link.serial_clk = sclk;
	assign link.frame_select_n = fs_n;
	assign link.serial_data_in = sdo;
	assign link.trigger = trig;
	assign link.abort = abort;
endmodule // scan_host

//--- scan_link_sva.sv
`timescale 1ns/1ps
// ****************
// Wire checks
// ****************
module scan_link_sva (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic serial_clk,
	input wire logic serial_data_in,
	input wire logic frame_select_n
);
	logic [7:0] falls;
	logic [7:0] next_falls;
	logic sclk_prev;
	always_comb begin
		next_falls = falls;
		if (frame_select_n) begin
			next_falls = 8'h00;
		end else if (sclk_prev && !serial_clk) begin
			next_falls = falls + 8'h01;
		end
	end
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			falls <= 8'h00;
			sclk_prev <= 1'b1;
		end else begin
			falls <= next_falls;
			sclk_prev <= serial_clk;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	chk_fs_before_fall: assert property ($fell(serial_clk) |-> $past(!frame_select_n))
		else $error("serial clock fell outside a frame");
	chk_word_multiple: assert property ($rose(frame_select_n) |-> (falls[3:0] == 4'h0) && (falls != 8'h00))
		else $error("frame ended off a word boundary");
	chk_idle_high: assert property (frame_select_n |-> serial_clk)
		else $error("serial clock not idle high");
	chk_low_half: assert property ($fell(serial_clk) |-> (!serial_clk) [*5] ##1 serial_clk)
		else $error("serial clock low phase wrong");
	chk_data_steady: assert property ((!serial_clk && $past(!serial_clk)) |-> $stable(serial_data_in))
		else $error("data moved while clock low");
	chk_fs_setup: assert property ($fell(frame_select_n) |-> serial_clk [*5] ##1 !serial_clk)
		else $error("frame start spacing wrong");
	chk_no_midword: assert property ((falls[3:0] != 4'h0) |-> !frame_select_n)
		else $error("frame raised inside a word");
	chk_high_half: assert property ($rose(serial_clk) |-> serial_clk [*5])
		else $error("serial clock high phase short");
endmodule // scan_link_sva

//--- freq_scan_sequencer_serial_tb_top.sv
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module freq_scan_sequencer_serial_tb_top;
	import scan_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_valid = 1'b0;
	word_t i_word = 16'h0000;
	logic i_more = 1'b0;
	logic i_trigger = 1'b0;
	logic i_abort = 1'b0;
	logic o_ready, o_busy, o_scanning, o_done, o_msb, scan2;
	freq_t o_freq, freq2, e;
	logic [11:0] o_dac, d0;
	int n_fail = 0;
	int compares = 0;
	int n;
	scan_link_if link();
	scan_link_if link2();
	always #50 i_clk = ~i_clk;
	scan_host scan_host_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .link(link.host),
		.i_valid(i_valid), .i_word(i_word), .i_more(i_more), .i_trigger(i_trigger),
		.i_abort(i_abort), .o_ready(o_ready), .o_busy(o_busy));
	scan_device scan_device_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .link(link.device),
		.o_freq(o_freq), .o_dac(o_dac), .o_msb(o_msb), .o_scanning(o_scanning), .o_done(o_done));
	// Second device faces the bench, which breaks framing on purpose
	scan_device scan_device_2_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .link(link2.device),
		.o_freq(freq2), .o_dac(), .o_msb(), .o_scanning(scan2), .o_done());
	scan_link_sva scan_link_sva_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.serial_clk(link.serial_clk), .serial_data_in(link.serial_data_in),
		.frame_select_n(link.frame_select_n));
	task tick; @(posedge i_clk); #1; endtask
	task report_and_stop;
		if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task cmp_freq(input freq_t g, input freq_t x);
		compares++;
		if (g !== x) begin n_fail++; $display("BAD %0t got %h exp %h", $time, g, x); end
	endtask
	task cmp_dac(input logic [11:0] g, input logic [11:0] x);
		compares++;
		if (g !== x) begin n_fail++; $display("BAD %0t got %h exp %h", $time, g, x); end
	endtask
	task cmp_bit(input logic g, input logic x);
		compares++;
		if (g !== x) begin n_fail++; $display("BAD %0t got %h exp %h", $time, g, x); end
	endtask
	function automatic bit cond(input int sel);
		case (sel)
			0: return o_ready === 1'b1;
			1: return o_busy === 1'b0;
			2: return o_scanning === 1'b1;
			3: return o_done === 1'b1;
			default: return scan2 === 1'b1;
		endcase
	endfunction
	// Bounded wait; n holds the cycles spent
	task wait_for(input int sel, input int lim);
		n = 0;
		while (!cond(sel)) begin
			tick;
			n++;
			if (n > lim) begin n_fail++; report_and_stop; end
		end
	endtask
	task send(input word_t w, input logic more);
		wait_for(0, 2000);
		i_word = w;
		i_more = more;
		i_valid = 1'b1;
		tick;
		i_valid = 1'b0;
	endtask
	task settle; wait_for(1, 4000); repeat (10) tick; endtask
	task trig; i_trigger = 1'b1; repeat (4) tick; i_trigger = 1'b0; repeat (6) tick; endtask
	// Bench-made link clock, 800 ns, idle level chosen per frame
	task raw(input word_t w, input int nb, input logic idle);
		// Idle level is set while deselected, so its change never counts as a bit
		link2.serial_clk = idle;
		#400;
		link2.frame_select_n = 1'b0;
		#400;
		for (int b = 15; b > 15 - nb; b--) begin
			link2.serial_clk = 1'b1;
			link2.serial_data_in = w[b];
			#400;
			link2.serial_clk = 1'b0;
			#400;
		end
		#400;
		link2.serial_clk = idle;
		link2.frame_select_n = 1'b1;
		link2.serial_data_in = ~link2.serial_data_in;
		#1600;
	endtask
	initial begin
		link2.serial_clk = 1'b1;
		link2.frame_select_n = 1'b1;
		link2.serial_data_in = 1'b0;
		link2.trigger = 1'b0;
		link2.abort = 1'b0;
		repeat (6) tick;
		i_reset_n = 1'b1;
		cmp_dac(o_dac, 12'h800);
		tick;
		send(16'h0000, 1'b1);
		send(16'h1002, 1'b1);
		send(16'h2010, 1'b1);
		send(16'h3000, 1'b1);
		send(16'hC100, 1'b1);
		send(16'hD000, 1'b1);
		send(16'h4014, 1'b0);
		settle;
		i_trigger = 1'b1;
		wait_for(2, 20);
		i_trigger = 1'b0;
		cmp_freq(o_freq, 24'h000100);
		repeat (10) tick;
		cmp_freq(o_freq, 24'h000100);
		repeat (20) tick;
		cmp_freq(o_freq, 24'h000110);
		repeat (20) tick;
		cmp_freq(o_freq, 24'h000120);
		wait_for(3, 40);
		cmp_bit(n >= 8 && n <= 12, 1'b1);
		repeat (200) tick;
		cmp_freq(o_freq, 24'h000120);
		cmp_bit(o_done, 1'b1);
		i_abort = 1'b1;
		repeat (4) tick;
		i_abort = 1'b0;
		repeat (6) tick;
		cmp_bit(o_done, 1'b0);
		cmp_freq(o_freq, 24'h000000);
		cmp_dac(o_dac, 12'h800);
		send(16'h0020, 1'b0);
		settle;
		for (int k = 0; k < 5; k++) begin
			trig;
			e = (k == 0) ? 24'h000100 : ((k == 1) ? 24'h000110 : 24'h000120);
			cmp_freq(o_freq, e);
			cmp_bit(o_done, k >= 3);
		end
		send(16'h0010, 1'b1);
		send(16'hC000, 1'b1);
		send(16'hD400, 1'b0);
		settle;
		i_trigger = 1'b1;
		wait_for(2, 20);
		i_trigger = 1'b0;
		wait_for(3, 400);
		cmp_bit(n >= 200 && n <= 260, 1'b1);
		cmp_freq(o_freq, 24'h400020);
		d0 = o_dac;
		tick;
		cmp_bit((o_dac - d0) == 12'h400 || (o_dac - d0) == 12'h401, 1'b1);
		cmp_bit(o_msb, ~o_dac[11]);
		raw(16'h0020, 16, 1'b0);
		raw(16'hC456, 8, 1'b1);
		raw(16'hC123, 16, 1'b1);
		link2.trigger = 1'b1;
		wait_for(4, 40);
		cmp_freq(freq2, 24'h000123);
		report_and_stop;
	end
endmodule // freq_scan_sequencer_serial_tb_top
